// ==== rtl/bltc_pkg.sv ====
// Package for the boolean logic trigger combiner
// Assumes a 32-bit APB slave on pclk
package bltc_pkg;
   // Register byte offsets
   localparam logic [11:0] BLTC_OFF_CTRL    = 12'h000; // Mode select and clears
   localparam logic [11:0] BLTC_OFF_FUNC_A0 = 12'h004; // Function A product 0
   localparam logic [11:0] BLTC_OFF_FUNC_A1 = 12'h008; // Function A product 1
   localparam logic [11:0] BLTC_OFF_FUNC_B0 = 12'h00c; // Function B product 0
   localparam logic [11:0] BLTC_OFF_FUNC_B1 = 12'h010; // Function B product 1
   localparam logic [11:0] BLTC_OFF_STATUS  = 12'h014; // Live state, read only
   // Product word field positions
   localparam int BLTC_POS_USE   = 0;  // [3:0] channel participates
   localparam int BLTC_POS_POL   = 4;  // [7:4] 1 = true form, 0 = complement
   localparam int BLTC_POS_EDGE  = 8;  // [8] product has an edge channel
   localparam int BLTC_POS_ECH   = 9;  // [10:9] edge channel index
   localparam int BLTC_POS_ERISE = 11; // [11] 1 = rising, 0 = falling
   localparam int BLTC_POS_VALID = 12; // [12] product programmed
   localparam int BLTC_PROD_W    = 13; // Product word width
   // Control field positions
   localparam int BLTC_POS_MODE  = 0;  // [1:0] mode
   localparam int BLTC_POS_CLRA  = 2;  // [2] write 1 clears function A
   localparam int BLTC_POS_CLRB  = 3;  // [3] write 1 clears function B
   // Reset values
   localparam logic [12:0] BLTC_RST_PROD = 13'h0000; // Cleared product
   localparam logic [1:0]  BLTC_RST_MODE = 2'h0;     // Function A alone
   // Trigger pulse length in cycles
   localparam int BLTC_PULSE_CYC = 1;

   // Trigger modes
   typedef enum logic [1:0] {
      BLTC_MODE_A,
      BLTC_MODE_B,
      BLTC_MODE_A_THEN_B
   } bltc_mode_e;

   // One programmed product
   typedef struct packed {
      logic       valid; // Product present
      logic       erise; // Edge direction
      logic [1:0] ech;   // Edge channel
      logic       edg;   // Edge qualified
      logic [3:0] pol;   // Polarity per channel
      logic [3:0] use_;  // Participating channels
   } bltc_prod_s;

   // One function: two products
   typedef struct packed {
      bltc_prod_s p1;
      bltc_prod_s p0;
   } bltc_func_s;

   // Evaluate one product from current and previous samples
   function automatic logic bltc_prod_eval(input bltc_prod_s p, input logic [3:0] cur,
                                           input logic [3:0] prv);
      logic [3:0] lvl;
      logic       ok;
      logic       trn;
      lvl = ~p.use_ | ~(cur ^ p.pol);
      ok  = &lvl;
      trn = p.erise ? (cur[p.ech] & ~prv[p.ech]) : (~cur[p.ech] & prv[p.ech]);
      bltc_prod_eval = p.valid & ok & (~p.edg | trn);
   endfunction

   // Evaluate one function as OR of its products
   function automatic logic bltc_func_eval(input bltc_func_s f, input logic [3:0] cur,
                                           input logic [3:0] prv);
      bltc_func_eval = bltc_prod_eval(f.p0, cur, prv) | bltc_prod_eval(f.p1, cur, prv);
   endfunction
endpackage

// ==== rtl/bltc_sampler.sv ====
// Channel sampler: registers the four comparator levels twice
// Assumes comparator outputs synchronous to pclk
`timescale 1ns/1ns
module bltc_sampler
   import bltc_pkg::*;
#(
   parameter int N = 4 // Channel count
)(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         clk_en,
   // Comparator levels
   input  wire logic [N-1:0] chan_in,
   // Samples
   output logic      [N-1:0] cur_ff,
   output logic      [N-1:0] prv_ff
);
   // Elaboration check
   if (N != 4) begin : g_bad_n
      $error("bltc_sampler supports exactly four channels");
   end

   // Sample now and previous sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff <= '0;
         prv_ff <= '0;
      end else if (clk_en) begin
         cur_ff <= chan_in; // RULE_14
         prv_ff <= cur_ff;  // RULE_14
      end
   end
endmodule

// ==== rtl/bltc_top.sv ====
// Boolean logic trigger combiner: APB registers, two functions, nesting
// Operation
// RULE_01 - Channel above threshold reads as logic one
// RULE_02 - Function is OR of AND products
// RULE_03 - At most two products over four channels
// RULE_04 - Each channel selectable true or complemented
// RULE_05 - Unused channels do not affect product
// RULE_06 - AND, OR, NOT behave as Boolean
// RULE_07 - One optional rising/falling edge per product
// RULE_08 - Edge product true only at transition
// RULE_09 - Nested: A arms, then B fires
// RULE_10 - Nested: B ignored until armed
// RULE_11 - Satisfied function emits trigger pulse
// RULE_12 - Two functions A, B plus nested mode
// RULE_13 - Reset input blocks trigger and arming
// RULE_14 - Sample on clock, edges versus previous
// RULE_15 - Cleared function never asserts
// Assumes comparator levels synchronous to pclk
`timescale 1ns/1ns
module bltc_top
   import bltc_pkg::*;
#(
   parameter int NCH = 4 // Channel count
)(
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Comparator outputs, one per channel
   input  wire logic        input_channel_1,
   input  wire logic        input_channel_2,
   input  wire logic        input_channel_3,
   input  wire logic        input_channel_4,
   // External trigger inhibit, active high
   input  wire logic        ext_reset,
   // Time base trigger
   output logic             trig_out,
   output logic             armed_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration check
   if (NCH != 4) begin : g_bad_nch
      $error("bltc_top supports exactly four channels");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      bltc_func_s  fa;      // Function A
      bltc_func_s  fb;      // Function B
      logic [1:0]  mode;    // Trigger mode
      logic        armed;   // Nested arm flag
      logic        trig;    // Trigger pulse
      logic        trig_st; // Sticky trigger seen
      logic [31:0] rdata;   // Read data
      logic        ready;   // APB ready
      logic        err;     // APB error
   } bltc_state_s;

   bltc_state_s st_ff;      // Registered state
   bltc_state_s nxt_st;     // Next state
   logic [3:0]  cur;        // Current samples
   logic [3:0]  prv;        // Previous samples
   logic        fa_hit;     // Function A true
   logic        fb_hit;     // Function B true
   logic        acc;        // APB access phase
   logic        wr;         // APB write taken
   logic        rd;         // APB read taken
   logic        mapped;     // Address decodes

   ////////////////////////////////////////////////////////////////////////////////
   // Channel sampling
   bltc_sampler #(
      .N (NCH)
   ) u_sampler (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .chan_in ({input_channel_4, input_channel_3, input_channel_2, input_channel_1}), // RULE_01
      .cur_ff  (cur),
      .prv_ff  (prv)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Function evaluation
   assign fa_hit = bltc_func_eval(st_ff.fa, cur, prv); // RULE_02
   assign fb_hit = bltc_func_eval(st_ff.fb, cur, prv); // RULE_12

   // APB decode
   assign acc    = psel & penable & ~st_ff.ready;
   assign wr     = acc & pwrite;
   assign rd     = acc & ~pwrite;
   assign mapped = (paddr == BLTC_OFF_CTRL) | (paddr == BLTC_OFF_FUNC_A0) |
                   (paddr == BLTC_OFF_FUNC_A1) | (paddr == BLTC_OFF_FUNC_B0) |
                   (paddr == BLTC_OFF_FUNC_B1) | (paddr == BLTC_OFF_STATUS);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.ready = acc;            // One wait state, then ready
      nxt_st.err   = acc & ~mapped;  // Unmapped address errors
      nxt_st.trig  = 1'b0;
      // Register writes
      if (wr) begin
         case (paddr)
            BLTC_OFF_CTRL: begin
               nxt_st.mode = pwdata[BLTC_POS_MODE +: 2];
               if (pwdata[BLTC_POS_CLRA]) begin
                  nxt_st.fa = '0; // RULE_15
               end
               if (pwdata[BLTC_POS_CLRB]) begin
                  nxt_st.fb = '0; // RULE_15
               end
               nxt_st.trig_st = 1'b0;
            end
            BLTC_OFF_FUNC_A0: nxt_st.fa.p0 = pwdata[BLTC_PROD_W-1:0]; // RULE_03
            BLTC_OFF_FUNC_A1: nxt_st.fa.p1 = pwdata[BLTC_PROD_W-1:0]; // RULE_03
            BLTC_OFF_FUNC_B0: nxt_st.fb.p0 = pwdata[BLTC_PROD_W-1:0]; // RULE_03
            BLTC_OFF_FUNC_B1: nxt_st.fb.p1 = pwdata[BLTC_PROD_W-1:0]; // RULE_03
            default: begin
               nxt_st.err = 1'b1; // Read-only or unmapped
            end
         endcase
      end
      // Register reads
      if (rd) begin
         case (paddr)
            BLTC_OFF_CTRL:    nxt_st.rdata = {30'h0, st_ff.mode};
            BLTC_OFF_FUNC_A0: nxt_st.rdata = {19'h0, st_ff.fa.p0};
            BLTC_OFF_FUNC_A1: nxt_st.rdata = {19'h0, st_ff.fa.p1};
            BLTC_OFF_FUNC_B0: nxt_st.rdata = {19'h0, st_ff.fb.p0};
            BLTC_OFF_FUNC_B1: nxt_st.rdata = {19'h0, st_ff.fb.p1};
            // Bit 9 sticky, 8 B true, 7 A true, 6 armed, 5:2 channels, 1:0 zero
            BLTC_OFF_STATUS:  nxt_st.rdata = {22'h0, st_ff.trig_st, fb_hit, fa_hit,
                                              st_ff.armed, cur, 2'h0};
            default:          nxt_st.rdata = 32'h00000000;
         endcase
      end
      // Trigger logic
      if (ext_reset) begin
         nxt_st.armed = 1'b0; // RULE_13
      end else begin
         case (st_ff.mode)
            BLTC_MODE_A: begin
               nxt_st.trig = fa_hit; // RULE_11
            end
            BLTC_MODE_B: begin
               nxt_st.trig = fb_hit; // RULE_11
            end
            BLTC_MODE_A_THEN_B: begin
               if (st_ff.armed && fb_hit) begin
                  nxt_st.trig  = 1'b1; // RULE_09
                  nxt_st.armed = 1'b0; // RULE_09
               end else if (fa_hit) begin
                  nxt_st.armed = 1'b1; // RULE_09
               end
               // Unarmed B occurrences fall through silently
               // RULE_10
            end
            default: begin
               nxt_st.trig  = 1'b0;
               nxt_st.armed = 1'b0;
            end
         endcase
      end
      // Sticky seen flag: the event wins over the clear
      if (nxt_st.trig) begin
         nxt_st.trig_st = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff      <= '0;
         st_ff.mode <= BLTC_RST_MODE;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign prdata    = st_ff.rdata;
   assign pready    = st_ff.ready;
   assign pslverr   = st_ff.err;
   assign trig_out  = st_ff.trig; // RULE_13
   assign armed_out = st_ff.armed;

   // Boolean operators come from the evaluation functions
   // RULE_04 RULE_05 RULE_06 RULE_07 RULE_08
endmodule

// ==== test/bltc_monitor.sv ====
// Port checker for the trigger combiner
// Assumes a bind onto bltc_top, one clock
`timescale 1ns/1ns
module bltc_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Trigger side
   input wire logic ext_reset,
   input wire logic trig_out,
   input wire logic armed_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   // Inhibit blocks the trigger and the arm
   rst_trig_a: assert property (ext_reset && clk_en |=> !trig_out) else $error("trigger while inhibited");
   rst_arm_a: assert property (ext_reset && clk_en |=> !armed_out) else $error("armed while inhibited");
   // Arming never coincides with a fire
   arm_quiet_a: assert property ($rose(armed_out) |-> !trig_out && !$past(ext_reset))
      else $error("arm with fire");
   // Disarm only by firing, outside inhibit and APB access
   disarm_fire_a: assert property ($fell(armed_out) && !$past(ext_reset) && !$past(psel) |-> trig_out)
      else $error("disarm without fire");
   // Frozen clock enable holds state
   freeze_hold_a: assert property (!clk_en && !ext_reset |=> $stable(trig_out) && $stable(armed_out))
      else $error("state moved while frozen");
   // One wait state, single-cycle answer
   apb_wait_a: assert property (psel && penable && !pready && clk_en |=> pready) else $error("pready late");
   ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("pready too long");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready unasked");
endmodule
bind bltc_top bltc_monitor u_mon (.pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
   .ext_reset, .trig_out, .armed_out);

// ==== test/bltc_timebase.sv ====
// Time base model: counts trigger pulses
// Assumes trig_out is a registered pulse on pclk
`timescale 1ns/1ns
module bltc_timebase (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Trigger from the combiner
   input  wire logic trig_out,
   // Pulses seen so far
   output int        trig_cnt_ff
);
   // One count per cycle the trigger is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_cnt_ff <= 0;
      end else if (trig_out === 1'b1) begin
         trig_cnt_ff <= trig_cnt_ff + 1;
      end
   end
endmodule

// ==== test/bltc_top_tb.sv ====
// Bench for the trigger combiner
// Assumes bltc_top, an APB master and the time base model
`timescale 1ns/1ns
module bltc_top_tb;
   import bltc_pkg::*;
   logic        pclk = 0, presetn = 0, clk_en = 1, ext_reset = 0;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, trig_out, armed_out;
   logic [3:0]  ch = 4'h0;
   int          failures = 0, n_compared = 0, n_trig, n;
   // Free-running clock
   always #10 pclk = ~pclk;
   ////////////////////////////////////////////////////////////
   bltc_top u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .input_channel_1(ch[0]), .input_channel_2(ch[1]), .input_channel_3(ch[2]),
      .input_channel_4(ch[3]), .ext_reset, .trig_out, .armed_out);
   bltc_timebase u_tbase (.pclk, .presetn, .trig_out, .trig_cnt_ff(n_trig));
   ////////////////////////////////////////////////////////////
   // Value comparison
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", name, exp, got);
      end
   endtask
   // One APB transfer, waits for pready
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic err);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Sample pready at each rising edge, hold the request until then
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      chk("pready", 1, pready);
      chk("pslverr", err, pslverr);
      psel <= 0;
      penable <= 0;
   endtask
   // Drive channels, wait edges, settle
   task automatic run(logic [3:0] v, int e);
      @(posedge pclk);
      ch <= v;
      repeat (e) @(posedge pclk);
      @(negedge pclk);
   endtask
   // Product word
   function automatic logic [31:0] pw(logic [3:0] u, p, logic e, logic [1:0] c, logic r);
      return {19'h0, 1'b1, r, c, e, p, u};
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(0, BLTC_OFF_CTRL, 32'h0, 0);
      chk("ctrl", 32'h0, rd);
      apb(0, BLTC_OFF_FUNC_A0, 32'h0, 0);
      chk("a0 reset", 32'h0, rd);
      apb(0, 12'h0fc, 32'h0, 1);
      chk("unmapped", 32'h0, rd);
      apb(1, BLTC_OFF_STATUS, 32'h1, 1);
   endtask
   task automatic t_level();
      logic e;
      apb(1, BLTC_OFF_FUNC_A0, pw(4'h5, 4'h1, 0, 0, 0), 0);
      apb(1, BLTC_OFF_FUNC_A1, pw(4'h2, 4'h2, 0, 0, 0), 0);
      for (int v = 0; v < 16; v++) begin
         e = (v[0] & ~v[2]) | v[1];
         run(v[3:0], 2);
         chk("level", {31'h0, e}, {31'h0, trig_out});
      end
      @(posedge pclk);
      clk_en <= 0;
      run(4'h0, 2);
      chk("frozen", 1, trig_out);
      @(posedge pclk);
      clk_en <= 1;
   endtask
   task automatic t_edge();
      apb(1, BLTC_OFF_FUNC_A1, 32'h0, 0);
      for (int r = 0; r < 2; r++) begin
         apb(1, BLTC_OFF_FUNC_A0, pw(4'h1, 4'h1, 1, 1, r[0]), 0);
         run(r ? 4'h1 : 4'h3, 3);
         n = n_trig;
         run(r ? 4'h3 : 4'h1, 5);
         chk("edge", n + 1, n_trig);
      end
      apb(1, BLTC_OFF_CTRL, 32'h4, 0);
      apb(0, BLTC_OFF_FUNC_A0, 32'h0, 0);
      chk("cleared", 32'h0, rd);
      run(4'h1, 2);
      run(4'h3, 5);
      chk("clr trig", n + 1, n_trig);
   endtask
   task automatic t_nested();
      apb(1, BLTC_OFF_FUNC_A0, pw(4'h1, 4'h1, 0, 0, 0), 0);
      apb(1, BLTC_OFF_FUNC_B0, pw(4'h2, 4'h2, 0, 0, 0), 0);
      run(4'h0, 3);
      apb(1, BLTC_OFF_CTRL, 32'h2, 0);
      n = n_trig;
      run(4'h2, 4);
      chk("unarmed", n, n_trig);
      run(4'h1, 2);
      run(4'h0, 3);
      chk("armed", 1, armed_out);
      run(4'h2, 4);
      chk("fired", n + 1, n_trig);
      chk("disarm", 0, armed_out);
      run(4'h1, 2);
      @(posedge pclk);
      ext_reset <= 1;
      run(4'h2, 4);
      chk("inhibit", n + 1, n_trig);
      chk("rst arm", 0, armed_out);
      @(posedge pclk);
      ext_reset <= 0;
      apb(1, BLTC_OFF_CTRL, 32'h1, 0);
      run(4'h2, 2);
      chk("mode b", 1, trig_out);
      apb(0, BLTC_OFF_STATUS, 32'h0, 0);
      chk("status", 32'h308, rd);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_level();
      t_edge();
      t_nested();
      report_and_stop();
   end
   // Watchdog
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end
endmodule
